// File: src/memtype_combiner.sv
// merges consecutive combining-type word stores into one quadword write
`timescale 1ns/1ps
`include "memtype_map.svh"

module memtype_combiner
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // word store in
    input wire logic i_valid,
    input wire logic [31:0] i_addr,
    input wire logic [15:0] i_data,
    input wire logic i_flush,
    output logic o_ready,
    // merged write out
    output logic o_valid,
    output logic [31:0] o_addr,
    output logic [63:0] o_data,
    output logic [7:0] o_be,
    input wire logic i_taken
);

    logic [63:0] data_reg;
    logic [7:0] be_reg;
    logic [28:0] qw_reg;
    logic open_reg;
    logic full_reg;
    logic [`COMB_IDX_W-1:0] idx;
    logic hit;
    logic emit;

    assign idx = i_addr[2:1];
    assign hit = open_reg && (qw_reg == i_addr[31:3]);
    // a store to another quadword forces the open one out first
    assign emit = open_reg && (full_reg || i_flush || (i_valid && !hit));
    assign o_ready = !full_reg && (!open_reg || hit);
    assign o_valid = emit;
    assign o_addr = {qw_reg, 3'h0};
    assign o_data = data_reg;
    assign o_be = be_reg;

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            data_reg <= 64'h0;
            be_reg <= 8'h00;
            qw_reg <= 29'h0;
            open_reg <= 1'b0;
            full_reg <= 1'b0;
        end
        else if (emit && i_taken)
        begin
            open_reg <= 1'b0;
            full_reg <= 1'b0;
            be_reg <= 8'h00;
        end
        else if (i_valid && o_ready)
        begin
            open_reg <= 1'b1;
            qw_reg <= i_addr[31:3];
            data_reg[idx*16 +: 16] <= i_data;
            be_reg[idx*2 +: 2] <= 2'h3;
            full_reg <= ((be_reg | (8'h03 << {idx, 1'b0})) == 8'hFF);
        end
    end

endmodule

// File: src/memtype_decode.sv
// decodes a resolved memory type into caching and buffering attributes
`timescale 1ns/1ps
`include "memtype_map.svh"

module memtype_decode
(
    // resolved type
    input wire logic [2:0] i_type,
    // attributes
    output logic o_read_cacheable,
    output logic o_write_cacheable,
    output logic o_read_alloc,
    output logic o_write_alloc,
    output logic o_spec_read,
    output logic o_combine,
    output logic o_buffer,
    output logic o_strict,
    output logic o_probe_all
);

    always_comb
    begin
        o_read_cacheable = 1'b0;
        o_write_cacheable = 1'b0;
        o_write_alloc = 1'b0;
        o_combine = 1'b0;
        o_buffer = 1'b0;
        o_strict = 1'b0;
        o_probe_all = 1'b0;
        case (i_type)
            `MT_CACHE_DISABLED:
            begin
                o_strict = 1'b1;
                o_probe_all = 1'b1;
            end
            `MT_COMBINING:
            begin
                o_combine = 1'b1;
                o_buffer = 1'b1;
            end
            `MT_COH_COMBINING:
            begin
                o_combine = 1'b1;
                o_buffer = 1'b1;
                o_probe_all = 1'b1;
            end
            `MT_WRITE_PROTECT:
            begin
                o_read_cacheable = 1'b1;
                o_buffer = 1'b1;
            end
            `MT_WRITE_THROUGH:
            begin
                o_read_cacheable = 1'b1;
                o_write_cacheable = 1'b1;
                o_buffer = 1'b1;
            end
            `MT_WRITE_BACK:
            begin
                o_read_cacheable = 1'b1;
                o_write_cacheable = 1'b1;
                o_write_alloc = 1'b1;
                o_buffer = 1'b1;
            end
            default:
            begin
                o_strict = 1'b1;
            end
        endcase
        // only strict types forbid speculative reads
        o_read_alloc = o_read_cacheable;
        o_spec_read = !o_strict;
    end

endmodule

// File: src/memtype_map.svh
// memory type codes, cache state codes and fixed counts for the policy block
`ifndef MEMTYPE_MAP_SVH
`define MEMTYPE_MAP_SVH

`define MT_UNCACHED 3'h0
`define MT_COMBINING 3'h1
`define MT_COH_COMBINING 3'h2
`define MT_CACHE_DISABLED 3'h3
`define MT_WRITE_THROUGH 3'h4
`define MT_WRITE_PROTECT 3'h5
`define MT_WRITE_BACK 3'h6

`define LS_INVALID 2'h0
`define LS_SHARED 2'h1
`define LS_EXCLUSIVE 2'h2
`define LS_MODIFIED 2'h3

`define COMB_WORDS 3'h4
`define COMB_IDX_W 2

`endif

// File: src/memtype_pkg.sv
// types shared by the memory type policy block
package memtype_pkg;
    typedef logic [2:0] mem_type_t;
    typedef logic [1:0] line_state_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_DRAIN = 6'h02,
        ST_INVAL = 6'h04,
        ST_MEM = 6'h08,
        ST_DONE = 6'h10,
        ST_FLUSH = 6'h20
    } req_state_t;
endpackage

// File: src/memtype_policy.sv
// applies a request's memory type to caches, write buffers and memory
// Functional notes
// - uncached: no caching, speculation or combining
// - drain and invalidate write buffers first
// - cache disable bit makes cacheable cache-disabled; this block does so only while caches are not invalidated
// - conflicting page and range types infer cache-disabled; this block infers it only when both are different cacheable types
// - cache-disabled data hit: write back, invalidate
// - hold access until invalidations complete
// - cache-disabled fetch hit uses cache, miss no-allocate
// - cache-disabled write invalidates instruction cache hit
// - combining: uncached, speculative reads allowed
// - combining stores merge into larger writes
// - coherent combining combines and probes all caches
// - write-protect reads cached, allocate, speculative
// - write-protect stores go to memory, invalidate hits
// - writethrough reads cached, allocate, speculative
// - writethrough stores update memory and hit line
// - writethrough store miss does not allocate
// - writeback reads allocate shared, exclusive or modified; this block always allocates exclusive
// - writeback store sets line modified, allocates miss
// - writeback writes memory only on line write-back
// - strict types keep order, no speculative writes
// - only writeback allocates writes
// - store hit on modified line keeps state
`timescale 1ns/1ps
`include "memtype_map.svh"

module memtype_policy
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // control state
    input wire logic i_cache_disable,
    input wire logic i_caches_invalidated,
    // request from load/store and fetch paths
    input wire logic i_req_valid,
    input wire logic [1:0] i_req_kind,
    input wire logic [2:0] i_page_type,
    input wire logic [2:0] i_range_type,
    input wire logic [31:0] i_req_addr,
    input wire logic [15:0] i_req_data,
    input wire logic i_req_spec,
    output logic o_req_ready,
    output logic o_req_done,
    output logic o_req_fault,
    // lookup results from caches
    input wire logic i_dc_hit,
    input wire logic [1:0] i_dc_state,
    input wire logic i_ic_hit,
    // cache actions
    output logic o_cache_read,
    output logic o_cache_write,
    output logic o_cache_alloc,
    output logic [1:0] o_cache_new_state,
    output logic o_dc_inval,
    output logic o_dc_writeback,
    output logic o_ic_inval,
    output logic o_probe_all,
    input wire logic i_inval_done,
    // write buffers
    output logic o_wbuf_push,
    output logic o_wbuf_drain,
    input wire logic i_wbuf_empty,
    // main memory
    output logic o_mem_valid,
    output logic o_mem_write,
    output logic [31:0] o_mem_addr,
    output logic [63:0] o_mem_data,
    output logic [7:0] o_mem_be,
    input wire logic i_mem_ready,
    // resolved type for observation
    output logic [2:0] o_eff_type
);

    localparam logic [1:0] KIND_LOAD = 2'h0;
    localparam logic [1:0] KIND_STORE = 2'h1;
    localparam logic [1:0] KIND_FETCH = 2'h2;

    // ==================================================================
    // type resolution
    // ==================================================================
    function automatic logic is_cacheable(input logic [2:0] t);
        is_cacheable = t inside {`MT_WRITE_BACK, `MT_WRITE_THROUGH,
            `MT_WRITE_PROTECT};
    endfunction

    function automatic logic [2:0] resolve(input logic [2:0] pg,
        input logic [2:0] rg,
        input logic cd,
        input logic clean);
        resolve = pg;
        if (pg == `MT_UNCACHED || rg == `MT_UNCACHED)
            resolve = `MT_UNCACHED;
        else if (pg == `MT_COMBINING || rg == `MT_COMBINING)
            resolve = `MT_COMBINING;
        else if (pg != rg && is_cacheable(pg) && is_cacheable(rg))
            resolve = `MT_CACHE_DISABLED;
        if (cd && !clean && is_cacheable(resolve))
            resolve = `MT_CACHE_DISABLED;
    endfunction

    logic [2:0] eff_type;
    assign eff_type = resolve(i_page_type, i_range_type, i_cache_disable,
        i_caches_invalidated);

    logic a_rd_cache;
    logic a_wr_cache;
    logic a_rd_alloc;
    logic a_wr_alloc;
    logic a_spec;
    logic a_combine;
    logic a_buffer;
    logic a_strict;
    logic a_probe;

    logic [2:0] type_reg;

    memtype_decode u_decode
    (
        .i_type(type_reg),
        .o_read_cacheable(a_rd_cache),
        .o_write_cacheable(a_wr_cache),
        .o_read_alloc(a_rd_alloc),
        .o_write_alloc(a_wr_alloc),
        .o_spec_read(a_spec),
        .o_combine(a_combine),
        .o_buffer(a_buffer),
        .o_strict(a_strict),
        .o_probe_all(a_probe)
    );

    // ==================================================================
    // request capture
    // ==================================================================
    memtype_pkg::req_state_t state_reg;
    logic [1:0] kind_reg;
    logic [31:0] addr_reg;
    logic [15:0] data_reg;
    logic is_store;
    logic is_fetch;
    logic take;
    logic spec_bad;

    assign is_store = (kind_reg == KIND_STORE);
    assign is_fetch = (kind_reg == KIND_FETCH);
    // speculative stores, and speculative reads of strict types, refused
    assign spec_bad = i_req_spec && ((i_req_kind == KIND_STORE) ||
        eff_type inside {`MT_UNCACHED, `MT_CACHE_DISABLED});
    assign o_req_ready = (state_reg == memtype_pkg::ST_IDLE);
    assign take = i_req_valid && o_req_ready && !spec_bad;
    assign o_eff_type = type_reg;

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            type_reg <= `MT_UNCACHED;
            kind_reg <= KIND_LOAD;
            addr_reg <= 32'h0;
            data_reg <= 16'h0;
        end
        else if (take)
        begin
            type_reg <= eff_type;
            kind_reg <= i_req_kind;
            addr_reg <= i_req_addr;
            data_reg <= i_req_data;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_req_fault <= 1'b0;
        else
            o_req_fault <= i_req_valid && o_req_ready && spec_bad;
    end

    // ==================================================================
    // combining path
    // ==================================================================
    logic cmb_in;
    logic cmb_ready;
    logic cmb_valid;
    logic [31:0] cmb_addr;
    logic [63:0] cmb_data;
    logic [7:0] cmb_be;
    logic cmb_taken;
    logic cmb_flush;
    logic direct_mem;

    assign cmb_in = (state_reg == memtype_pkg::ST_MEM) && is_store &&
        a_combine;
    // strict accesses push any open combined write out ahead of them
    assign cmb_flush = (state_reg == memtype_pkg::ST_FLUSH) && a_strict;
    assign cmb_taken = cmb_valid && i_mem_ready && !direct_mem;

    memtype_combiner u_comb
    (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_valid(cmb_in),
        .i_addr(addr_reg),
        .i_data(data_reg),
        .i_flush(cmb_flush),
        .o_ready(cmb_ready),
        .o_valid(cmb_valid),
        .o_addr(cmb_addr),
        .o_data(cmb_data),
        .o_be(cmb_be),
        .i_taken(cmb_taken)
    );

    // ==================================================================
    // sequencing
    // ==================================================================
    logic needs_inval;
    logic mem_needed;

    // hit lines under cache-disabled are written back and invalidated
    assign needs_inval = (type_reg == `MT_CACHE_DISABLED) &&
        ((!is_fetch && i_dc_hit) || (is_store && i_ic_hit)) ||
        (type_reg == `MT_WRITE_PROTECT && is_store && i_dc_hit);
    assign mem_needed =
        (is_store && type_reg != `MT_WRITE_BACK && !a_combine) ||
        (!is_store && !(a_rd_cache && i_dc_hit) &&
         !(is_fetch && type_reg == `MT_CACHE_DISABLED && i_ic_hit));
    assign direct_mem = (state_reg == memtype_pkg::ST_MEM) && mem_needed;

    memtype_pkg::req_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            memtype_pkg::ST_IDLE:
            begin
                if (take)
                    state_next = memtype_pkg::ST_FLUSH;
            end
            memtype_pkg::ST_FLUSH:
            begin
                if (!a_strict || !cmb_valid || cmb_taken)
                    state_next = a_strict ? memtype_pkg::ST_DRAIN :
                        (needs_inval ? memtype_pkg::ST_INVAL :
                        memtype_pkg::ST_MEM);
            end
            memtype_pkg::ST_DRAIN:
            begin
                if (i_wbuf_empty)
                    state_next = needs_inval ? memtype_pkg::ST_INVAL :
                                 memtype_pkg::ST_MEM;
            end
            memtype_pkg::ST_INVAL:
            begin
                if (i_inval_done)
                    state_next = memtype_pkg::ST_MEM;
            end
            memtype_pkg::ST_MEM:
            begin
                if (cmb_in ? cmb_ready : (!mem_needed || i_mem_ready))
                    state_next = memtype_pkg::ST_DONE;
            end
            memtype_pkg::ST_DONE:
            begin
                state_next = memtype_pkg::ST_IDLE;
            end
            default:
            begin
                state_next = memtype_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state_reg <= memtype_pkg::ST_IDLE;
        else
            state_reg <= state_next;
    end

    assign o_req_done = (state_reg == memtype_pkg::ST_DONE);

    // ==================================================================
    // cache and buffer actions
    // ==================================================================
    logic in_mem;
    assign in_mem = (state_reg == memtype_pkg::ST_MEM);

    assign o_wbuf_drain = (state_reg == memtype_pkg::ST_DRAIN);
    assign o_probe_all = a_probe && (state_reg == memtype_pkg::ST_INVAL ||
        in_mem);
    assign o_dc_inval = (state_reg == memtype_pkg::ST_INVAL) &&
        i_dc_hit && !is_fetch;
    assign o_dc_writeback = o_dc_inval &&
        (i_dc_state == `LS_MODIFIED);
    assign o_ic_inval = (state_reg == memtype_pkg::ST_INVAL) && is_store &&
        i_ic_hit;

    // read hit served from cache; cache-disabled fetch hit too
    assign o_cache_read = in_mem && !is_store &&
        ((a_rd_cache && i_dc_hit) ||
        (is_fetch && type_reg == `MT_CACHE_DISABLED && i_ic_hit));
    assign o_cache_write = in_mem && is_store && a_wr_cache &&
        (i_dc_hit || a_wr_alloc);
    assign o_cache_alloc = in_mem && !i_dc_hit &&
        ((!is_store && a_rd_alloc) || (is_store && a_wr_alloc));
    // write-protect and writethrough stores travel through the write buffer
    assign o_wbuf_push = in_mem && is_store && a_buffer && !a_combine &&
        type_reg != `MT_WRITE_BACK && i_mem_ready;

    always_comb
    begin
        o_cache_new_state = i_dc_state;
        if (is_store && type_reg == `MT_WRITE_BACK)
            o_cache_new_state = `LS_MODIFIED;
        else if (!is_store && !i_dc_hit)
            o_cache_new_state = `LS_EXCLUSIVE;
    end

    // ==================================================================
    // memory request
    // ==================================================================
    assign o_mem_valid = direct_mem || (cmb_valid && !direct_mem);
    // writeback stores never reach memory here: only line write-back does
    assign o_mem_write = direct_mem ? is_store : 1'b1;
    assign o_mem_addr = direct_mem ? addr_reg : cmb_addr;
    assign o_mem_data = direct_mem ? {48'h0, data_reg} : cmb_data;
    assign o_mem_be = direct_mem ? 8'h03 : cmb_be;

endmodule

// File: tb/mem_side_model.sv
// far side model: write buffers, invalidation and main memory
`timescale 1ns/1ps

module mem_side_model
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // pacing and requests
    input wire logic i_slow,
    input wire logic i_inval,
    input wire logic i_wbuf_push,
    input wire logic i_wbuf_drain,
    input wire logic i_mem_valid,
    // answers
    output logic o_inval_done,
    output logic o_wbuf_empty,
    output logic o_mem_ready
);
    logic [2:0] mem_cnt_reg;
    logic [2:0] inv_cnt_reg;
    logic [3:0] wbuf_cnt_reg;
    logic [2:0] lat;
    assign lat = i_slow ? 3'h3 : 3'h0;
    assign o_mem_ready = i_mem_valid && mem_cnt_reg >= lat;
    assign o_inval_done = i_inval && inv_cnt_reg > lat;
    assign o_wbuf_empty = wbuf_cnt_reg == 4'h0;
    always_ff @(posedge i_core_clk or negedge i_rst_n)
        if (!i_rst_n)
            mem_cnt_reg <= 3'h0;
        else
            mem_cnt_reg <= o_mem_ready ? 3'h0 : mem_cnt_reg + 3'(i_mem_valid);
    always_ff @(posedge i_core_clk or negedge i_rst_n)
        if (!i_rst_n)
            inv_cnt_reg <= 3'h0;
        else
            inv_cnt_reg <= o_inval_done ? 3'h0 : inv_cnt_reg + 3'(i_inval);
    // one buffered entry retires per drain cycle
    always_ff @(posedge i_core_clk or negedge i_rst_n)
        if (!i_rst_n)
            wbuf_cnt_reg <= 4'h0;
        else
            wbuf_cnt_reg <= wbuf_cnt_reg + {3'h0, i_wbuf_push}
                - {3'h0, i_wbuf_drain && !o_wbuf_empty};
endmodule

// File: tb/memtype_policy_props.sv
// assertion checker for the memory type policy block
`timescale 1ns/1ps
`include "memtype_map.svh"

module memtype_policy_props
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // request side
    input wire logic i_cache_disable,
    input wire logic i_caches_invalidated,
    input wire logic i_req_valid,
    input wire logic [1:0] i_req_kind,
    input wire logic [2:0] i_page_type,
    input wire logic [2:0] i_range_type,
    input wire logic i_req_spec,
    input wire logic o_req_ready,
    input wire logic o_req_fault,
    // cache and memory side
    input wire logic [1:0] i_dc_state,
    input wire logic o_cache_write,
    input wire logic o_cache_alloc,
    input wire logic [1:0] o_cache_new_state,
    input wire logic o_dc_inval,
    input wire logic o_probe_all,
    input wire logic i_inval_done,
    input wire logic i_wbuf_empty,
    input wire logic o_mem_valid,
    input wire logic o_mem_write,
    input wire logic [2:0] o_eff_type
);
    // =========================================
    // properties
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    wire take = i_req_valid && o_req_ready && !i_req_spec;

    a_spec_store_fault:
        assert property (i_req_valid && o_req_ready && i_req_spec
            && i_req_kind == 2'h1 |=> o_req_fault) else $error("no fault");
    a_strict_drained:
        assert property (o_mem_valid && o_eff_type == `MT_UNCACHED
            |-> i_wbuf_empty) else $error("buffers not drained");
    a_inval_holds_mem:
        assert property (o_dc_inval && !i_inval_done |=> !o_mem_valid)
        else $error("memory before invalidation");
    a_disable_bit_type:
        assert property (take && i_cache_disable && !i_caches_invalidated
            && i_page_type == `MT_WRITE_BACK && i_range_type ==
            `MT_WRITE_BACK |=> o_eff_type == `MT_CACHE_DISABLED)
        else $error("disable bit ignored");
    a_conflict_type:
        assert property (take && i_page_type == `MT_WRITE_THROUGH
            && i_range_type == `MT_WRITE_BACK
            |=> o_eff_type == `MT_CACHE_DISABLED) else $error("conflict");
    a_alloc_types:
        assert property (o_cache_alloc |-> o_eff_type inside
            {`MT_WRITE_PROTECT, `MT_WRITE_THROUGH, `MT_WRITE_BACK})
        else $error("allocation for uncached type");
    a_write_cache_types:
        assert property (o_cache_write |-> o_eff_type inside
            {`MT_WRITE_THROUGH, `MT_WRITE_BACK}) else $error("cache write");
    a_write_alloc_back:
        assert property (o_cache_alloc && o_cache_write
            |-> o_eff_type == `MT_WRITE_BACK) else $error("write alloc");
    a_back_modified:
        assert property (o_cache_write && o_eff_type == `MT_WRITE_BACK
            |-> o_cache_new_state == `LS_MODIFIED) else $error("not dirty");
    a_through_state:
        assert property (o_cache_write && o_eff_type == `MT_WRITE_THROUGH
            |-> o_cache_new_state == i_dc_state) else $error("state moved");
    a_coherent_probe:
        assert property (o_mem_valid && !o_mem_write && o_eff_type ==
            `MT_COH_COMBINING |-> o_probe_all) else $error("no probe");

    cover property (o_dc_inval && i_inval_done);
    cover property (o_req_fault);
    cover property (o_cache_alloc && o_cache_write);
endmodule

// File: tb/tb_memtype_policy.sv
// self-checking bench for the memory type policy block
`timescale 1ns/1ps
`include "memtype_map.svh"

module tb_memtype_policy;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic dis = 0, inv = 0, valid = 0, spec = 0, dc_hit = 0, ic_hit = 0;
    logic slow = 0;
    logic [1:0] kind = 2'h0, dc_st = 2'h0, st, nst;
    logic [2:0] pt = 3'h0, rt = 3'h0, eff;
    logic [31:0] addr = 32'h0, m_a;
    logic [63:0] m_d;
    logic [7:0] be;
    logic [10:0] seen;
    logic ready, done, fault, c_rd, c_wr, c_al, dinv, dwb, iinv, probe;
    logic push, drain, m_v, m_w, inv_done, wb_empty, m_rdy;
    int n_mismatch = 0, cmp_count = 0, nquad = 0;

    always #5 i_core_clk = ~i_core_clk;

    memtype_policy memtype_policy_inst (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .i_cache_disable(dis), .i_caches_invalidated(inv),
        .i_req_valid(valid), .i_req_kind(kind), .i_page_type(pt),
        .i_range_type(rt), .i_req_addr(addr), .i_req_data(addr[17:2]),
        .i_req_spec(spec), .o_req_ready(ready), .o_req_done(done),
        .o_req_fault(fault), .i_dc_hit(dc_hit), .i_dc_state(dc_st),
        .i_ic_hit(ic_hit), .o_cache_read(c_rd), .o_cache_write(c_wr),
        .o_cache_alloc(c_al), .o_cache_new_state(nst), .o_dc_inval(dinv),
        .o_dc_writeback(dwb), .o_ic_inval(iinv), .o_probe_all(probe),
        .i_inval_done(inv_done), .o_wbuf_push(push), .o_wbuf_drain(drain),
        .i_wbuf_empty(wb_empty), .o_mem_valid(m_v), .o_mem_write(m_w),
        .o_mem_addr(m_a), .o_mem_data(m_d), .o_mem_be(be),
        .i_mem_ready(m_rdy), .o_eff_type(eff));

    mem_side_model mem_side_model_inst (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .i_slow(slow), .i_inval(dinv | iinv),
        .i_wbuf_push(push), .i_wbuf_drain(drain), .i_mem_valid(m_v),
        .o_inval_done(inv_done), .o_wbuf_empty(wb_empty),
        .o_mem_ready(m_rdy));

    // =========================================
    // monitor: sticky flags of the current request
    always @(posedge i_core_clk)
    begin
        seen <= seen | {fault, c_rd, probe, drain, iinv, dwb, dinv, c_wr,
            c_al, m_w & m_v, m_v};
        if (c_wr || c_al)
            st <= nst;
        if (m_v && m_rdy && m_w && be == 8'hFF && m_a == 32'h300
            && m_d == 64'h00C1_00C1_00C0_00C0)
            nquad <= nquad + 1;
    end

    // =========================================
    // shared tasks
    task automatic chk(input string nm, input logic [10:0] exp, got);
        cmp_count++;
        if (exp !== got)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic req(input logic [1:0] k, input logic [2:0] p,
        input logic s, input logic [31:0] a);
        int n;
        @(negedge i_core_clk);
        kind = k;
        pt = p;
        rt = p;
        spec = s;
        addr = a;
        valid = 1'b1;
        seen = '0;
        @(negedge i_core_clk);
        valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && seen[10] !== 1'b1 && n < 60)
        begin
            @(negedge i_core_clk);
            n++;
        end
        chk("completion", 11'h000, {10'h000, n == 60});
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // =========================================
    // scenarios
    task automatic t_strict;
        req(2'h1, `MT_WRITE_THROUGH, 1'b0, 32'h40);
        req(2'h0, `MT_UNCACHED, 1'b0, 32'h80);
        chk("strict flags", 11'h081, seen & 11'h28D);
        chk("strict type", 11'h000, {8'h00, eff});
        $display("t_strict done");
    endtask

    task automatic t_disabled;
        dc_hit = 1'b1;
        dc_st = `LS_MODIFIED;
        dis = 1'b1;
        slow = 1'b1;
        req(2'h0, `MT_WRITE_BACK, 1'b0, 32'h100);
        chk("dis load", 11'h031, seen & 11'h035);
        chk("dis type", 11'h003, {8'h00, eff});
        dc_hit = 1'b0;
        ic_hit = 1'b1;
        req(2'h1, `MT_WRITE_BACK, 1'b0, 32'h104);
        chk("dis store", 11'h041, seen & 11'h04D);
        inv = 1'b1;
        ic_hit = 1'b0;
        req(2'h0, `MT_WRITE_BACK, 1'b0, 32'h108);
        chk("clean type", 11'h006, {8'h00, eff});
        dis = 1'b0;
        inv = 1'b0;
        slow = 1'b0;
        ic_hit = 1'b1;
        pt = `MT_WRITE_THROUGH;
        for (int i = 0; i < 2; i++)
        begin
            @(negedge i_core_clk);
            {kind, rt, spec, addr, valid, seen} = {2'h2, `MT_WRITE_BACK,
                1'b0, 32'h200, 1'b1, 11'h000};
            @(negedge i_core_clk);
            valid = 1'b0;
            repeat (20) @(negedge i_core_clk);
            chk("fetch", {10'h000, ~ic_hit}, seen & 11'h005);
            chk("fetch type", 11'h003, {8'h00, eff});
            ic_hit = 1'b0;
        end
        $display("t_disabled done");
    endtask

    task automatic t_combine;
        int n0;
        n0 = nquad;
        for (int i = 0; i < 4; i++)
            req(2'h1, `MT_COMBINING, 1'b0, 32'h300 + 32'(2 * i));
        repeat (10) @(negedge i_core_clk);
        chk("quad writes", 11'h001, 11'(nquad - n0));
        req(2'h0, `MT_COH_COMBINING, 1'b0, 32'h400);
        chk("coh load", 11'h101, seen & 11'h105);
        $display("t_combine done");
    endtask

    task automatic t_cacheable;
        logic [2:0] ty [3] = '{`MT_WRITE_PROTECT, `MT_WRITE_THROUGH,
            `MT_WRITE_BACK};
        logic [10:0] eh [3] = '{11'h012, 11'h00A, 11'h008};
        logic [10:0] em [3] = '{11'h002, 11'h002, 11'h004};
        logic [1:0] hs [3] = '{`LS_SHARED, `LS_MODIFIED, `LS_SHARED};
        slow = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            dc_hit = 1'b0;
            req(2'h0, ty[i], 1'b0, 32'h500);
            chk("read miss", 11'h005, seen & 11'h005);
            chk("read state", 11'h002, {9'h000, st});
            dc_hit = 1'b1;
            dc_st = hs[i];
            req(2'h1, ty[i], 1'b0, 32'h504);
            chk("st hit", eh[i], seen&11'h1A);
            if (i > 0)
                chk("hit state", 11'h003, {9'h000, st});
            dc_hit = 1'b0;
            req(2'h1, ty[i], 1'b0, 32'h508);
            chk("store miss", em[i], seen & 11'h006);
        end
        slow = 1'b0;
        $display("t_cacheable done");
    endtask

    task automatic t_spec;
        logic [1:0] k [4] = '{2'h1, 2'h0, 2'h0, 2'h0};
        logic [2:0] t [4] = '{`MT_WRITE_BACK, `MT_UNCACHED, `MT_WRITE_BACK,
            `MT_COMBINING};
        logic [10:0] e [4] = '{11'h400, 11'h400, 11'h001, 11'h001};
        for (int i = 0; i < 4; i++)
        begin
            req(k[i], t[i], 1'b1, 32'h600);
            chk("spec", e[i], seen & 11'h401);
        end
        $display("t_spec done");
    endtask

    initial
    begin
        repeat (10) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        t_strict();
        t_disabled();
        t_combine();
        t_cacheable();
        t_spec();
        summarize();
    end

    initial
    begin
        #50000;
        n_mismatch++;
        summarize();
    end
endmodule

bind memtype_policy memtype_policy_props memtype_policy_props_inst (.*);
